// ===== core/pscc_pkg.sv
// Package: command, status codes and register layout for the port codec
package pscc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MEAS_CMD = 8'h12;
  localparam logic [7:0] OFS_DEV_STATUS = 8'h1D;
  localparam logic [7:0] OFS_FW_REV_MID = 8'h62;
  localparam logic [7:0] OFS_FW_REV_LOW = 8'h63;
  localparam int DEV_STATUS_BACKOFF_BIT = 0;
  localparam logic [7:0] DEV_STATUS_RST = 8'h00;
  // Arbitrary neutral revision values
  localparam logic [7:0] FW_REV_MID_DEF = 8'h01;
  localparam logic [7:0] FW_REV_LOW_DEF = 8'h01;

  // ---------------------------------------------------------------
  // Command opcodes (bits 5:2) and port field (bits 1:0)
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_POWER_ON = 4'h1,
    OP_POWER_OFF = 4'h2,
    OP_RESET_PORT = 4'h3,
    OP_TOGGLE_BACKOFF = 4'h4,
    OP_RESET_CHIP = 4'h5,
    OP_GET_SUPPLY = 4'h6,
    OP_READ_CURRENT = 4'h7,
    OP_SHED_LOW_PRIO = 4'h8
  } pscc_opcode_t;
  localparam int CMD_OP_LSB = 2;
  localparam int CMD_PORT_LSB = 0;

  // ---------------------------------------------------------------
  // Status encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_UNKNOWN = 3'h0,
    DET_SHORT = 3'h1,
    DET_RSVD2 = 3'h2,
    DET_RLOW = 3'h3,
    DET_GOOD = 3'h4,
    DET_RHIGH = 3'h5,
    DET_ROPEN = 3'h6,
    DET_RSVD7 = 3'h7
  } pscc_detect_t;

  typedef enum logic [2:0] {
    CLS_UNKNOWN = 3'h0,
    CLS_ONE = 3'h1,
    CLS_TWO = 3'h2,
    CLS_THREE = 3'h3,
    CLS_FOUR = 3'h4,
    CLS_PROBES_NE = 3'h5,
    CLS_ZERO = 3'h6,
    CLS_OVERLOAD = 3'h7
  } pscc_class_t;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMIAUTO = 2'h2,
    MODE_AUTO = 2'h3
  } pscc_mode_t;

  // Cut thresholds chosen in automatic mode
  localparam logic [7:0] CUT_CLASS1 = 8'h1E;
  localparam logic [7:0] CUT_CLASS2 = 8'h35;
  localparam logic [7:0] CUT_SINGLE = 8'h75;
  localparam logic [7:0] CUT_DOUBLE = 8'hC9;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BACKOFF_MS = 2000;
  localparam longint BACKOFF_CYC = longint'(BACKOFF_MS) * 1000 * CLK_MHZ;

  // One port's classification input and measurement word
  typedef struct packed {
    logic done;
    pscc_class_t cls;
  } pscc_class_evt_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } pscc_result_t;
endpackage

// ===== core/pscc_cmd_decode.sv
// Command byte decoder for the port codec
`timescale 1ns/1ns
`default_nettype none
module pscc_cmd_decode
  import pscc_pkg::*;
(
  input wire logic [7:0] cmd_byte,
  output logic [3:0] port_onehot,
  output logic is_on,
  output logic is_off,
  output logic is_rst_port,
  output logic is_toggle,
  output logic is_rst_chip,
  output logic is_supply,
  output logic is_current,
  output logic is_shed
);
  // ---------------------------------------------------------------
  // Field split
  // ---------------------------------------------------------------
  wire logic [3:0] op = cmd_byte[CMD_OP_LSB +: 4];
  wire logic [1:0] port = cmd_byte[CMD_PORT_LSB +: 2];
  // Parameterless codes need the port field zero and top bits clear
  wire logic top_ok = (cmd_byte[7:6] == 2'h0);
  wire logic no_par = top_ok && (port == 2'h0);

  // Opcode match; unknown codes match nothing (see RULE19)
  assign port_onehot = 4'h1 << port; // see RULE6
  assign is_on = top_ok && (op == OP_POWER_ON); // see RULE7
  assign is_off = top_ok && (op == OP_POWER_OFF); // see RULE8
  assign is_rst_port = top_ok && (op == OP_RESET_PORT); // see RULE9
  assign is_toggle = no_par && (op == OP_TOGGLE_BACKOFF); // see RULE10
  assign is_rst_chip = no_par && (op == OP_RESET_CHIP); // see RULE12
  assign is_supply = no_par && (op == OP_GET_SUPPLY); // see RULE13
  assign is_current = top_ok && (op == OP_READ_CURRENT); // see RULE14
  assign is_shed = no_par && (op == OP_SHED_LOW_PRIO); // see RULE15
endmodule
`default_nettype wire

// ===== core/pscc_cut_select.sv
// Automatic-mode cut threshold selection from a class result
`timescale 1ns/1ns
`default_nettype none
module pscc_cut_select
  import pscc_pkg::*;
(
  input wire pscc_class_t cls,
  input wire logic enh_power,
  output logic load,
  output logic [7:0] cut
);
  // ---------------------------------------------------------------
  // Class to threshold table
  // ---------------------------------------------------------------
  // Faulty classes leave the threshold untouched
  assign load = (cls == CLS_ONE) || (cls == CLS_TWO) ||
                (cls == CLS_THREE) || (cls == CLS_ZERO) ||
                (cls == CLS_FOUR);
  assign cut = (cls == CLS_ONE) ? CUT_CLASS1 : // see RULE4
               (cls == CLS_TWO) ? CUT_CLASS2 : // see RULE4
               (cls == CLS_FOUR && enh_power) ? CUT_DOUBLE : // see RULE5
               CUT_SINGLE; // see RULE18
endmodule
`default_nettype wire

// ===== core/pscc_codec.sv
// Top: command interpreter and port status for a four-port controller
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1 - Detection result reported as 3-bit code
// RULE2 - Class result reported as 3-bit code
// RULE3 - Port mode held as 2-bit code
// RULE4 - Auto mode loads cut from class
// RULE5 - Class four loads single or doubled cut
// RULE6 - Port number sits in command bits 1:0
// RULE7 - Opcode 1 powers selected port on
// RULE8 - Opcode 2 powers selected port off
// RULE9 - Opcode 3 resets only selected port
// RULE10 - Opcode 4 toggles status bit 0
// RULE11 - Back-off bit set waits two seconds
// RULE12 - Opcode 5 resets whole controller; here the device status register keeps its value
// RULE13 - Opcode 6 returns supply in millivolts
// RULE14 - Opcode 7 returns port current
// RULE15 - Opcode 8 sheds low-priority ports
// RULE16 - Measurements sampled at command write, unfiltered
// RULE17 - Class four with enhanced power reclassifies
// RULE18 - Doubled cut only with enhanced power
// RULE19 - Unknown opcode leaves ports untouched
module pscc_codec
  import pscc_pkg::*;
#(
  parameter int NPORT = 4,
  parameter longint BACKOFF_CYCLES = BACKOFF_CYC
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port: byte write/read at documented offsets
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic [15:0] meas_ff,
  output logic meas_valid_ff,
  // Per-port inputs from the analog front end
  input wire logic [NPORT*3-1:0] det_code,
  input wire pscc_class_evt_t [NPORT-1:0] class_evt,
  input wire logic [NPORT*2-1:0] mode_in,
  input wire logic [NPORT-1:0] mode_load,
  input wire logic [NPORT-1:0] enh_power,
  input wire logic [NPORT-1:0] low_prio,
  input wire logic [15:0] supply_mv,
  input wire logic [NPORT*16-1:0] port_current,
  // Per-port outputs
  output logic [NPORT-1:0] power_on_ff,
  output logic [NPORT-1:0] port_reset_ff,
  output logic [NPORT-1:0] reclass_ff,
  output logic chip_reset_ff,
  output logic detect_go_ff,
  output logic [NPORT*2-1:0] mode_ff,
  output logic [NPORT*3-1:0] det_stat_ff,
  output logic [NPORT*3-1:0] cls_stat_ff,
  output logic [NPORT*8-1:0] overload_cut_threshold_ff
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rstn = rst_s2_ff;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0] sel;
  logic c_on, c_off, c_rp, c_tog, c_rc, c_sup, c_cur, c_shed;
  wire logic cmd_wr = reg_wr && (reg_addr == OFS_MEAS_CMD);

  pscc_cmd_decode u_dec (
    .cmd_byte(reg_wdata),
    .port_onehot(sel),
    .is_on(c_on),
    .is_off(c_off),
    .is_rst_port(c_rp),
    .is_toggle(c_tog),
    .is_rst_chip(c_rc),
    .is_supply(c_sup),
    .is_current(c_cur),
    .is_shed(c_shed)
  );

  wire logic [NPORT-1:0] port_sel = sel[NPORT-1:0];
  wire logic w_on = cmd_wr && c_on;
  wire logic w_off = cmd_wr && c_off;
  wire logic w_rp = cmd_wr && c_rp;
  wire logic w_tog = cmd_wr && c_tog;
  wire logic w_rc = cmd_wr && c_rc;
  wire logic w_sup = cmd_wr && c_sup;
  wire logic w_cur = cmd_wr && c_cur;
  wire logic w_shed = cmd_wr && c_shed;

  // ---------------------------------------------------------------
  // Device status register and chip reset
  // ---------------------------------------------------------------
  logic [7:0] dev_status_ff;
  // Chip reset is a one-cycle pulse; port state and detection pacing return to reset, the status register keeps its value
  wire logic soft_clr = chip_reset_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dev_status_ff <= DEV_STATUS_RST;
      chip_reset_ff <= 1'b0;
    end else begin
      chip_reset_ff <= w_rc; // see RULE12
      if (w_tog) // see RULE10
        dev_status_ff[DEV_STATUS_BACKOFF_BIT] <=
          ~dev_status_ff[DEV_STATUS_BACKOFF_BIT];
      else if (reg_wr && reg_addr == OFS_DEV_STATUS)
        dev_status_ff <= reg_wdata;
    end
  end
  wire logic backoff_en = dev_status_ff[DEV_STATUS_BACKOFF_BIT];

  // ---------------------------------------------------------------
  // Detection pacing: go pulse each attempt, spaced when backed off
  // ---------------------------------------------------------------
  // Counter holds at zero when back-off is off, so attempts run freely
  logic [39:0] wait_ff;
  wire logic wait_done = (wait_ff == 40'h0);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 40'h0;
      detect_go_ff <= 1'b0;
    end else begin
      detect_go_ff <= wait_done && !soft_clr;
      if (soft_clr || !backoff_en)
        wait_ff <= 40'h0;
      else if (wait_done) // see RULE11
        wait_ff <= 40'(BACKOFF_CYCLES - 1);
      else
        wait_ff <= wait_ff - 40'h1;
    end
  end

  // ---------------------------------------------------------------
  // Measurement capture at command write, no filtering
  // ---------------------------------------------------------------
  wire logic [15:0] cur_sel = port_current[reg_wdata[1:0]*16 +: 16];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meas_ff <= 16'h0000;
      meas_valid_ff <= 1'b0;
    end else begin
      meas_valid_ff <= w_sup || w_cur;
      if (w_sup) // see RULE13, see RULE16
        meas_ff <= supply_mv;
      else if (w_cur) // see RULE14, see RULE16
        meas_ff <= cur_sel;
    end
  end

  // ---------------------------------------------------------------
  // Per-port state
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic ld;
      logic [7:0] cut;
      pscc_mode_t md;
      pscc_class_t cl;
      assign md = pscc_mode_t'(mode_ff[p*2 +: 2]);
      assign cl = class_evt[p].cls;
      pscc_cut_select u_cut (
        .cls(cl),
        .enh_power(enh_power[p]),
        .load(ld),
        .cut(cut)
      );
      // Only defined opcodes touch the port (see RULE19)
      wire logic hit_on = w_on && port_sel[p];
      wire logic hit_off = w_off && port_sel[p];
      wire logic hit_rp = w_rp && port_sel[p];
      wire logic hit_shed = w_shed && low_prio[p];
      wire logic auto_cls = class_evt[p].done && (md == MODE_AUTO);

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          power_on_ff[p] <= 1'b0;
          port_reset_ff[p] <= 1'b0;
          reclass_ff[p] <= 1'b0;
          mode_ff[p*2 +: 2] <= MODE_SHUTDOWN;
          det_stat_ff[p*3 +: 3] <= DET_UNKNOWN;
          cls_stat_ff[p*3 +: 3] <= CLS_UNKNOWN;
          overload_cut_threshold_ff[p*8 +: 8] <= CUT_SINGLE;
        end else if (soft_clr) begin
          power_on_ff[p] <= 1'b0;
          port_reset_ff[p] <= 1'b0;
          reclass_ff[p] <= 1'b0;
          mode_ff[p*2 +: 2] <= MODE_SHUTDOWN;
          det_stat_ff[p*3 +: 3] <= DET_UNKNOWN;
          cls_stat_ff[p*3 +: 3] <= CLS_UNKNOWN;
          overload_cut_threshold_ff[p*8 +: 8] <= CUT_SINGLE;
        end else begin
          port_reset_ff[p] <= hit_rp; // see RULE9
          det_stat_ff[p*3 +: 3] <= det_code[p*3 +: 3]; // see RULE1
          if (class_evt[p].done)
            cls_stat_ff[p*3 +: 3] <= cl; // see RULE2
          if (mode_load[p])
            mode_ff[p*2 +: 2] <= mode_in[p*2 +: 2]; // see RULE3
          if (hit_off || hit_shed || hit_rp) // see RULE8, see RULE15
            power_on_ff[p] <= 1'b0;
          else if (hit_on) // see RULE7
            power_on_ff[p] <= 1'b1;
          // Second event only after a first class-four result
          reclass_ff[p] <= auto_cls && (cl == CLS_FOUR) &&
                           enh_power[p] && !reclass_ff[p]; // see RULE17
          if (auto_cls && ld) // see RULE4, see RULE5, see RULE18
            overload_cut_threshold_ff[p*8 +: 8] <= cut;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------
  wire logic [7:0] rd_mux =
    (reg_addr == OFS_DEV_STATUS) ? dev_status_ff :
    (reg_addr == OFS_FW_REV_MID) ? FW_REV_MID_DEF :
    (reg_addr == OFS_FW_REV_LOW) ? FW_REV_LOW_DEF : 8'h00;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      reg_rdata_ff <= 8'h00;
    else if (reg_rd)
      reg_rdata_ff <= rd_mux;
  end
endmodule
`default_nettype wire

// ===== test/pscc_codec_properties.sv
// Checker: command and status assertions at the codec ports
`timescale 1ns/1ns
`default_nettype none
module pscc_codec_properties
  import pscc_pkg::*;
#(
  parameter int NPORT = 4
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [15:0] meas_ff,
  input wire logic meas_valid_ff,
  input wire pscc_class_evt_t [NPORT-1:0] class_evt,
  input wire logic [NPORT-1:0] enh_power,
  input wire logic [NPORT-1:0] low_prio,
  input wire logic [15:0] supply_mv,
  input wire logic [NPORT*16-1:0] port_current,
  input wire logic [NPORT-1:0] power_on_ff,
  input wire logic [NPORT-1:0] port_reset_ff,
  input wire logic [NPORT-1:0] reclass_ff,
  input wire logic chip_reset_ff,
  input wire logic [NPORT*2-1:0] mode_ff,
  input wire logic [NPORT*8-1:0] overload_cut_threshold_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] port_ff;
  logic [15:0] cur_ff;
  logic [7:0] cut_ff;
  // Command decode as seen on the register port
  wire cmd = reg_wr && reg_addr == 8'h12;
  wire [5:0] op = reg_wdata[7:2];
  wire [2:0] c0 = class_evt[0].cls;
  wire cls_ld = class_evt[0].done && mode_ff[1:0] == 2'h3;
  // Expected cut for port 0; other ports share the same logic
  wire [7:0] exp_cut = (c0 == 3'h1) ? 8'h1E : (c0 == 3'h2) ? 8'h35 :
    (c0 == 3'h4 && enh_power[0]) ? 8'hC9 : 8'h75;
  // Context captured at the write edge, so the check sees the cause
  always_ff @(posedge sys_clk) begin
    port_ff <= reg_wdata[1:0];
    cur_ff <= port_current[reg_wdata[1:0]*16 +: 16];
    cut_ff <= exp_cut;
  end
  sequence s_reset_pulse;
    (port_reset_ff == (NPORT'(1) << port_ff)) && !power_on_ff[port_ff]
      ##1 port_reset_ff == '0;
  endsequence
  sequence s_chip_pulse;
    chip_reset_ff ##1 (!chip_reset_ff && power_on_ff == '0);
  endsequence
  a_power_on_cmd: assert property (cmd && op == 6'h01 |=> power_on_ff[port_ff]) else $error("power on missed");
  a_power_off_cmd: assert property (cmd && op == 6'h02 |=> !power_on_ff[port_ff]) else $error("power off missed");
  a_port_reset: assert property (cmd && op == 6'h03 |=> s_reset_pulse) else $error("port reset wrong");
  a_chip_reset: assert property (cmd && reg_wdata == 8'h14 |=> s_chip_pulse) else $error("chip reset wrong");
  a_supply_read: assert property (cmd && reg_wdata == 8'h18 |=> meas_valid_ff && meas_ff == $past(supply_mv)) else $error("supply word wrong");
  a_current_read: assert property (cmd && op == 6'h07 |=> meas_valid_ff && meas_ff == cur_ff) else $error("current word wrong");
  a_shed_low: assert property (cmd && reg_wdata == 8'h20 |=> (power_on_ff & $past(low_prio)) == '0) else $error("low priority kept");
  a_unknown_op: assert property (cmd && (op == 6'h00 || op > 6'h08) |=> $stable(power_on_ff) && port_reset_ff == '0) else $error("unknown op acted");
  a_auto_cut: assert property (cls_ld && c0 != 3'h0 && (c0 <= 3'h4 || c0 == 3'h6) |=> overload_cut_threshold_ff[7:0] == cut_ff) else $error("auto cut wrong");
  a_reclass_req: assert property (cls_ld |=> reclass_ff[0] == $past(c0 == 3'h4 && enh_power[0])) else $error("reclass wrong");
endmodule
bind pscc_codec pscc_codec_properties #(.NPORT(NPORT)) u_props (.sys_clk, .rst_n,
  .reg_wr, .reg_addr, .reg_wdata, .meas_ff, .meas_valid_ff, .class_evt,
  .enh_power, .low_prio, .supply_mv, .port_current, .power_on_ff,
  .port_reset_ff, .reclass_ff, .chip_reset_ff, .mode_ff,
  .overload_cut_threshold_ff);
`default_nettype wire

// ===== test/pscc_host_model.sv
// Host model: register accesses toward the port codec
`timescale 1ns/1ns
`default_nettype none
module pscc_host_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Command byte: opcode above the two port bits
  function automatic logic [7:0] cmd(input logic [3:0] op, input logic [1:0] p);
    return {2'b00, op, p};
  endfunction
  // One strobe cycle after an optional stall; on release the strobes drop and address and data are inverted
  // so a stale value can never pass for a held one
  task automatic access(input logic w, input logic [7:0] a,
    input logic [7:0] d, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ===== test/pscc_codec_test.sv
// Testbench for the port command and status codec
`timescale 1ns/1ns
`default_nettype none
module pscc_codec_test;
  import pscc_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, meas_valid_ff, chip_reset_ff;
  logic detect_go_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, mode_in, mode_ff, cut;
  logic [15:0] meas_ff, supply_mv;
  logic [11:0] det_code, det_stat_ff, cls_stat_ff;
  pscc_class_evt_t [3:0] class_evt;
  logic [3:0] mode_load, enh_power, low_prio, power_on_ff, pw;
  logic [3:0] port_reset_ff, reclass_ff;
  logic [63:0] port_current;
  logic [31:0] overload_cut_threshold_ff;
  logic [31:0] lfsr = 32'hB6D40DD8;
  logic [15:0] mq[$];
  logic [7:0] rq[$];
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  pscc_host_model H (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  pscc_codec #(.NPORT(4), .BACKOFF_CYCLES(10)) DUT (.sys_clk, .rst_n,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .meas_ff,
    .meas_valid_ff, .det_code, .class_evt, .mode_in, .mode_load,
    .enh_power, .low_prio, .supply_mv, .port_current, .power_on_ff,
    .port_reset_ff, .reclass_ff, .chip_reset_ff, .detect_go_ff, .mode_ff,
    .det_stat_ff, .cls_stat_ff, .overload_cut_threshold_ff);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    H.access(1'b1, 8'h12, d, lfsr[0]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    H.access(1'b0, a, 8'h00, 0);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Results are compared once settled, oldest note first
  always @(posedge sys_clk) begin
    logic r;
    r = reg_rd;
    #2;
    if (r) chk(reg_rdata_ff, rq.pop_front());
    if (meas_valid_ff === 1'b1) chk(meas_ff, mq.pop_front());
  end
  // Hang guard, well beyond the few hundred cycles of the run
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {det_code, class_evt, mode_in, mode_load, enh_power} = '0;
    {low_prio, supply_mv, port_current} = '0;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(overload_cut_threshold_ff, 32'h75757575);
    rd(8'h62, FW_REV_MID_DEF);
    rd(8'h63, FW_REV_LOW_DEF);
    rd(8'h40, 8'h00);
    rd(8'h1D, 8'h00);
    chk(detect_go_ff, 1);
    for (int p = 0; p < 4; p++) begin
      wr(H.cmd(4'h1, p[1:0]));
      chk(power_on_ff, (1 << (p + 1)) - 1);
      port_current = {rnd(), rnd()};
      mq.push_back(port_current[p*16 +: 16]);
      wr(H.cmd(4'h7, p[1:0]));
    end
    supply_mv = 16'(rnd());
    mq.push_back(supply_mv);
    wr(8'h18);
    low_prio = 4'(rnd());
    wr(8'h20);
    chk(power_on_ff, 4'(~low_prio));
    wr(H.cmd(4'h1, 2'h2));
    wr(H.cmd(4'h2, 2'h2));
    chk(power_on_ff[2], 0);
    wr(H.cmd(4'h1, 2'h3));
    wr(H.cmd(4'h3, 2'h3));
    chk(power_on_ff[3], 0);
    pw = power_on_ff;
    for (int b = 0; b < 256; b += 4) begin
      if (b == 0 || b > 32) wr(b[7:0] | rnd() & 8'h03);
    end
    chk(power_on_ff, pw);
    wr(8'h10);
    rd(8'h1D, 8'h01);
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      #1;
      n += detect_go_ff;
    end
    chk(n, 3);
    wr(8'h10);
    rd(8'h1D, 8'h00);
    for (int m = 0; m < 2; m++) begin
      mode_in = m ? 8'hFF : 8'hE4;
      mode_load = 4'hF;
      @(posedge sys_clk);
      #1 mode_load = 4'h0;
      @(posedge sys_clk);
      #1 chk(mode_ff, mode_in);
    end
    cut = 8'h75;
    for (int c = 0; c < 16; c++) begin
      case (c[2:0])
        3'h1: cut = 8'h1E;
        3'h2: cut = 8'h35;
        3'h3, 3'h6: cut = 8'h75;
        3'h4: cut = c[3] ? 8'hC9 : 8'h75;
        default: cut = cut;
      endcase
      class_evt[0].done = 1'b1;
      class_evt[0].cls = pscc_class_t'(c[2:0]);
      enh_power[0] = c[3];
      @(posedge sys_clk);
      #1 class_evt[0].done = 1'b0;
      chk(cls_stat_ff[2:0], c[2:0]);
      chk(reclass_ff[0], c[2:0] == 3'h4 && c[3]);
      chk(overload_cut_threshold_ff[7:0], cut);
    end
    det_code = 12'(rnd());
    repeat (2) @(posedge sys_clk);
    #1 chk(det_stat_ff, det_code);
    wr(H.cmd(4'h1, 2'h0));
    wr(8'h10);
    wr(8'h14);
    @(posedge sys_clk);
    #1 chk(power_on_ff, 0);
    rd(8'h1D, 8'h01);
    repeat (3) @(posedge sys_clk);
    complete_run();
  end
endmodule
`default_nettype wire
